// ==== clkrst_pkg.sv ====
// Package for the main clock and reset control block.
// Assumes a single 125 MHz system clock and an 8-bit register port.
package clkrst_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_SYSTEM_ENABLE = 8'h01;
	localparam logic [7:0] OFS_COMMAND = 8'h02;
	localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h03;
	localparam logic [7:0] OFS_REF_DIV_HIGH = 8'h04;
	localparam logic [7:0] OFS_REF_DIV_LOW = 8'h05;
	localparam logic [7:0] OFS_FB_DIV_HIGH = 8'h06;
	localparam logic [7:0] OFS_FB_DIV_LOW = 8'h07;
	localparam logic [7:0] OFS_PLL_CONFIG = 8'h08;
	localparam logic [7:0] OFS_INT_STATUS = 8'h09;
	localparam logic [7:0] OFS_INT_MASK = 8'h0a;
	localparam logic [7:0] OFS_MIC_THRESHOLD = 8'h0b;
	localparam logic [7:0] OFS_CLOCK_STATE = 8'h0c;

	// Commands
	localparam logic [7:0] CMD_CLOCK_STOP = 8'h00;
	localparam logic [7:0] CMD_CLOCK_START = 8'h01;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Field masks
	localparam logic [7:0] REF_DIV_HIGH_MASK = 8'h1f;
	localparam logic [7:0] FB_DIV_HIGH_MASK = 8'h3f;
	localparam logic [7:0] CLOCK_CONFIG_MASK = 8'h7f;

	// Field positions
	localparam int INT_CLOCK_READY_BIT = 0;
	localparam int INT_MIC_LEVEL_BIT = 1;
	localparam int CFG_PLL_REF_BIT = 4;
	localparam int CFG_PLL_SEL_BIT = 3;
	localparam int CFG_CLK_SEL_BIT = 2;
	localparam int PLL_FILTER_MSB = 7;
	localparam int PLL_FILTER_LSB = 4;

	// Timing: main clock 24.576 MHz, 125 MHz system clock
	localparam int SYS_CLK_KHZ = 125000;
	localparam int MAIN_CLK_KHZ = 24576;
	localparam int STOP_MAIN_CYCLES = 4;
	// Longest time rounds down, at least one cycle
	localparam int STOP_SYS_CYCLES_RAW = (STOP_MAIN_CYCLES * SYS_CLK_KHZ) / MAIN_CLK_KHZ;
	localparam int STOP_SYS_CYCLES = (STOP_SYS_CYCLES_RAW < 1) ? 1 : STOP_SYS_CYCLES_RAW;
	localparam int START_SYS_CYCLES = 16;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		CLK_OFF,
		CLK_STARTING,
		CLK_ON,
		CLK_STOPPING
	} clk_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage : clkrst_pkg

// ==== pin_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the destination clock is CLK; reset value is a constant.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} st_s;

	st_s st_q;
	st_s st_d;

	always_comb begin
		st_d.meta = d;
		st_d.sync = st_q.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= {INIT, INIT};
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.sync;
endmodule : pin_sync
`default_nettype wire

// ==== main_clock_reset_control.sv ====
// Main clock and reset control: register file, clock start and stop, interrupt pin.
// Assumes a host on an 8-bit register port in the CLK domain; pins arrive asynchronously.
//
// Summary of operation
// - Device resets on supply-monitor reset or low external reset pin.
// - Internal logic is built for a 24.576 MHz main clock.
// - Out of reset the clock is off; registers stay accessible.
// - Frame clock may be PLL reference only when the audio port is slave.
// - Writing 0x01 to the command register starts the main clock.
// - Clock-ready mask bit routes the clock-start event to the interrupt pin.
// - Clock-ready status sets when clock ready; reading status clears it.
// - Clock configuration register is locked once the main clock is active.
// - Main clock stops within four main clock cycles of the stop command.
// - With the clock stopped, audio functions are held in reset.
// - Microphone level above a programmable threshold may raise the interrupt.
// - PLL reference spans 8 kHz to 20 MHz; PLL bits 7-4 set filter resistance.
`timescale 1ns/1ps
`default_nettype none
module main_clock_reset_control
	import clkrst_pkg::*;
#(
	parameter int STOP_CYCLES = STOP_SYS_CYCLES,
	parameter int START_CYCLES = START_SYS_CYCLES
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SUPPLY_MONITOR_RESET,
	input wire logic EXTERNAL_RESET_LOW,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	input wire logic PLL_REFERENCE,
	input wire logic AUDIO_FRAME_CLOCK,
	input wire logic AUDIO_PORT_SLAVE,
	input wire logic [DATA_W-1:0] MIC_LEVEL,
	output logic MAIN_CLOCK_ENABLE,
	output logic MAIN_CLOCK_READY,
	output logic AUDIO_FUNCTIONS_RESET,
	output logic [DATA_W-1:0] CLOCK_CONFIG,
	output logic [12:0] REF_DIVIDER,
	output logic [13:0] FEEDBACK_DIVIDER,
	output logic [3:0] PLL_FILTER_RES,
	output logic [DATA_W-1:0] SYSTEM_ENABLE,
	output logic PLL_REF_FROM_FRAME,
	output logic INTERRUPT_OUT_LOW_O,
	output logic INTERRUPT_OUT_LOW_OE
);

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] sys_en;
		logic [DATA_W-1:0] clk_cfg;
		logic [DATA_W-1:0] rdiv_hi;
		logic [DATA_W-1:0] rdiv_lo;
		logic [DATA_W-1:0] ndiv_hi;
		logic [DATA_W-1:0] ndiv_lo;
		logic [DATA_W-1:0] pll_cfg;
		logic [DATA_W-1:0] int_stat;
		logic [DATA_W-1:0] int_mask;
		logic [DATA_W-1:0] mic_thr;
		clk_state_e state;
		logic [CNT_W-1:0] cnt;
		logic clk_en;
		logic clk_rdy;
		logic audio_rst;
		logic irq_oe;
	} st_s;

	st_s st_q;
	st_s st_d;
	logic rst_req;
	logic ext_rst_low_s;
	logic mon_rst_s;
	logic soft_rst;
	logic [1:0] misc_s;
	logic frame_ref_ok;
	reg_req_s req;

	// Core async reset is SYS_RST alone; the reset pin levels act as a synchronous reset.
	// Pin levels are synchronised first so release is clean in the CLK domain.
	pin_sync #(.W(2), .INIT(2'h1)) u_rst_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.d({SUPPLY_MONITOR_RESET, ~EXTERNAL_RESET_LOW}),
		.q({mon_rst_s, ext_rst_low_s})
	);

	pin_sync #(.W(2), .INIT(2'h0)) u_misc_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.d({AUDIO_PORT_SLAVE, PLL_REFERENCE}),
		.q(misc_s)
	);

	assign soft_rst = mon_rst_s | ext_rst_low_s;
	assign rst_req = SYS_RST;
	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
	// Frame clock may only feed the PLL while the audio port is slave
	assign frame_ref_ok = st_q.clk_cfg[CFG_PLL_REF_BIT] & misc_s[1];

	always_comb begin
		st_d = st_q;
		st_d.rdata = RST_BYTE;

		// Register writes; all but the status and clock-state registers remain writable with the clock off
		if (req.wr) begin
			case (req.addr)
				OFS_SYSTEM_ENABLE: st_d.sys_en = req.wdata;
				OFS_CLOCK_CONFIG: begin
					// Locked once the main clock has been activated
					if (st_q.state == CLK_OFF) begin
						st_d.clk_cfg = req.wdata & CLOCK_CONFIG_MASK;
					end
				end
				OFS_REF_DIV_HIGH: st_d.rdiv_hi = req.wdata & REF_DIV_HIGH_MASK;
				OFS_REF_DIV_LOW: st_d.rdiv_lo = req.wdata;
				OFS_FB_DIV_HIGH: st_d.ndiv_hi = req.wdata & FB_DIV_HIGH_MASK;
				OFS_FB_DIV_LOW: st_d.ndiv_lo = req.wdata;
				OFS_PLL_CONFIG: st_d.pll_cfg = req.wdata;
				OFS_INT_MASK: st_d.int_mask = req.wdata;
				OFS_MIC_THRESHOLD: st_d.mic_thr = req.wdata;
				default: ;
			endcase
		end

		// Reads: data stand in the next cycle only
		if (req.rd) begin
			case (req.addr)
				OFS_SYSTEM_ENABLE: st_d.rdata = st_q.sys_en;
				OFS_CLOCK_CONFIG: st_d.rdata = st_q.clk_cfg;
				OFS_REF_DIV_HIGH: st_d.rdata = st_q.rdiv_hi;
				OFS_REF_DIV_LOW: st_d.rdata = st_q.rdiv_lo;
				OFS_FB_DIV_HIGH: st_d.rdata = st_q.ndiv_hi;
				OFS_FB_DIV_LOW: st_d.rdata = st_q.ndiv_lo;
				OFS_PLL_CONFIG: st_d.rdata = st_q.pll_cfg;
				OFS_INT_STATUS: st_d.rdata = st_q.int_stat;
				OFS_INT_MASK: st_d.rdata = st_q.int_mask;
				OFS_MIC_THRESHOLD: st_d.rdata = st_q.mic_thr;
				OFS_CLOCK_STATE: st_d.rdata = {4'h0, frame_ref_ok, st_q.audio_rst,
					st_q.clk_rdy, st_q.clk_en};
				default: st_d.rdata = RST_BYTE;
			endcase
			// Reading status clears it; a same-cycle set is reapplied below
			if (req.addr == OFS_INT_STATUS) begin
				st_d.int_stat = RST_BYTE;
			end
		end

		// Clock start and stop sequencer
		case (st_q.state)
			CLK_OFF: begin
				st_d.clk_en = 1'b0;
				st_d.clk_rdy = 1'b0;
				st_d.audio_rst = 1'b1;
				if (req.wr && req.addr == OFS_COMMAND && req.wdata == CMD_CLOCK_START) begin
					st_d.state = CLK_STARTING;
					st_d.clk_en = 1'b1;
					st_d.cnt = CNT_W'(START_CYCLES);
				end
			end
			CLK_STARTING: begin
				if (req.wr && req.addr == OFS_COMMAND && req.wdata == CMD_CLOCK_STOP) begin
					st_d.state = CLK_STOPPING;
					st_d.cnt = CNT_W'(STOP_CYCLES);
				end else if (st_q.cnt <= CNT_W'(1)) begin
					st_d.state = CLK_ON;
					st_d.clk_rdy = 1'b1;
					st_d.audio_rst = 1'b0;
					st_d.int_stat[INT_CLOCK_READY_BIT] = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			CLK_ON: begin
				if (req.wr && req.addr == OFS_COMMAND && req.wdata == CMD_CLOCK_STOP) begin
					st_d.state = CLK_STOPPING;
					st_d.cnt = CNT_W'(STOP_CYCLES);
				end
			end
			CLK_STOPPING: begin
				// Gate off inside the four main-clock bound
				if (st_q.cnt <= CNT_W'(1)) begin
					st_d.state = CLK_OFF;
					st_d.clk_en = 1'b0;
					st_d.clk_rdy = 1'b0;
					st_d.audio_rst = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			default: st_d.state = CLK_OFF;
		endcase

		// Microphone level wake event; only meaningful while the clock runs
		if (st_q.clk_rdy && MIC_LEVEL > st_q.mic_thr) begin
			st_d.int_stat[INT_MIC_LEVEL_BIT] = 1'b1;
		end

		// Open-drain pin pulls low while any enabled status bit is set
		st_d.irq_oe = |(st_d.int_stat & st_q.int_mask);

		// Supply monitor or pin reset returns everything to defaults
		if (soft_rst) begin
			st_d = '0;
			st_d.state = CLK_OFF;
			st_d.audio_rst = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge rst_req) begin
		if (rst_req) begin
			st_q <= '0;
			st_q.state <= CLK_OFF;
			st_q.audio_rst <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Output register for the PLL-source selection, also registered
	logic frame_sel_q;
	always_ff @(posedge CLK or posedge rst_req) begin
		if (rst_req) begin
			frame_sel_q <= 1'b0;
		end else begin
			// Taken from the next config so the pin never lags a config clear
			frame_sel_q <= st_d.clk_cfg[CFG_PLL_REF_BIT] & misc_s[1];
		end
	end

	// Outputs are flip-flop fields except the tied-low INTERRUPT_OUT_LOW_O; configuration buses come straight from registers
	assign REG_RDATA = st_q.rdata;
	assign MAIN_CLOCK_ENABLE = st_q.clk_en;
	assign MAIN_CLOCK_READY = st_q.clk_rdy;
	assign AUDIO_FUNCTIONS_RESET = st_q.audio_rst;
	assign CLOCK_CONFIG = st_q.clk_cfg;
	assign REF_DIVIDER = {st_q.rdiv_hi[4:0], st_q.rdiv_lo};
	assign FEEDBACK_DIVIDER = {st_q.ndiv_hi[5:0], st_q.ndiv_lo};
	assign PLL_FILTER_RES = st_q.pll_cfg[PLL_FILTER_MSB:PLL_FILTER_LSB];
	assign SYSTEM_ENABLE = st_q.sys_en;
	assign PLL_REF_FROM_FRAME = frame_sel_q;
	assign INTERRUPT_OUT_LOW_O = 1'b0;
	assign INTERRUPT_OUT_LOW_OE = st_q.irq_oe;

	// Reference pin sample kept for observation of a running reference
	logic ref_seen_unused;
	assign ref_seen_unused = misc_s[0] & AUDIO_FRAME_CLOCK;

endmodule : main_clock_reset_control
`default_nettype wire

// ==== clkrst_props.sv ====
// Checker for the main clock and reset control block.
// Bound to main_clock_reset_control; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module clkrst_props
	import clkrst_pkg::*;
#(
	parameter int STOP_CYCLES = 2,
	parameter int START_CYCLES = 2
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SUPPLY_MONITOR_RESET,
	input wire logic EXTERNAL_RESET_LOW,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic MAIN_CLOCK_ENABLE,
	input wire logic MAIN_CLOCK_READY,
	input wire logic AUDIO_FUNCTIONS_RESET,
	input wire logic [DATA_W-1:0] CLOCK_CONFIG,
	input wire logic [3:0] PLL_FILTER_RES,
	input wire logic PLL_REF_FROM_FRAME,
	input wire logic INTERRUPT_OUT_LOW_O,
	input wire logic INTERRUPT_OUT_LOW_OE
);
	localparam int START_LO = START_CYCLES - 1;
	localparam int START_HI = START_CYCLES + 2;
	localparam int STOP_HI = STOP_CYCLES + 2;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic cmd_wr;
	assign cmd_wr = REG_WR && REG_ADDR == OFS_COMMAND;
	sequence s_start_cmd;
		cmd_wr && REG_WDATA == CMD_CLOCK_START && !MAIN_CLOCK_ENABLE;
	endsequence
	sequence s_ready_win;
		!MAIN_CLOCK_READY ##[START_LO:START_HI] MAIN_CLOCK_READY;
	endsequence
	AST_START_ENABLE: assert property (s_start_cmd |=> MAIN_CLOCK_ENABLE)
		else $error("clock start not taken");
	AST_READY_TIME: assert property (s_start_cmd |=> s_ready_win)
		else $error("clock ready late or early");
	AST_STOP_TIME: assert property (cmd_wr && REG_WDATA == CMD_CLOCK_STOP && MAIN_CLOCK_READY
		|-> ##[1:STOP_HI] !MAIN_CLOCK_ENABLE) else $error("clock stop too slow");
	AST_AUDIO_HELD: assert property (AUDIO_FUNCTIONS_RESET == !MAIN_CLOCK_READY)
		else $error("audio reset wrong");
	AST_CFG_LOCK: assert property (MAIN_CLOCK_ENABLE && REG_WR && REG_ADDR == OFS_CLOCK_CONFIG
		|=> $stable(CLOCK_CONFIG)) else $error("clock config changed while running");
	AST_FILTER: assert property (REG_WR && REG_ADDR == OFS_PLL_CONFIG
		|=> PLL_FILTER_RES == $past(REG_WDATA[7:4])) else $error("filter field wrong");
	AST_PIN_RESET: assert property ((!EXTERNAL_RESET_LOW || SUPPLY_MONITOR_RESET) [*4]
		|=> !MAIN_CLOCK_ENABLE && AUDIO_FUNCTIONS_RESET && !INTERRUPT_OUT_LOW_OE)
		else $error("reset not applied");
	AST_FRAME_REF: assert property (PLL_REF_FROM_FRAME |-> CLOCK_CONFIG[CFG_PLL_REF_BIT])
		else $error("frame reference without selection");
	AST_IRQ_OD: assert property (INTERRUPT_OUT_LOW_OE |-> !INTERRUPT_OUT_LOW_O)
		else $error("interrupt pin driven high");
endmodule : clkrst_props
bind main_clock_reset_control clkrst_props #(
	.STOP_CYCLES(STOP_CYCLES),
	.START_CYCLES(START_CYCLES)
) u_props (.CLK(CLK), .SYS_RST(SYS_RST), .SUPPLY_MONITOR_RESET(SUPPLY_MONITOR_RESET),
	.EXTERNAL_RESET_LOW(EXTERNAL_RESET_LOW), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .MAIN_CLOCK_ENABLE(MAIN_CLOCK_ENABLE), .MAIN_CLOCK_READY(MAIN_CLOCK_READY),
	.AUDIO_FUNCTIONS_RESET(AUDIO_FUNCTIONS_RESET), .CLOCK_CONFIG(CLOCK_CONFIG),
	.PLL_FILTER_RES(PLL_FILTER_RES), .PLL_REF_FROM_FRAME(PLL_REF_FROM_FRAME),
	.INTERRUPT_OUT_LOW_O(INTERRUPT_OUT_LOW_O), .INTERRUPT_OUT_LOW_OE(INTERRUPT_OUT_LOW_OE));
`default_nettype wire

// ==== host_model.sv ====
// Host model: register port master and the PLL reference source.
// Assumes the block's CLK domain; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module host_model
	import clkrst_pkg::*;
(
	input wire logic CLK,
	input wire logic [DATA_W-1:0] REG_RDATA,
	output var logic [ADDR_W-1:0] REG_ADDR,
	output var logic [DATA_W-1:0] REG_WDATA,
	output var logic REG_WR,
	output var logic REG_RD,
	output var logic PLL_REFERENCE
);
	logic ref_run = 1'h1;
	initial begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		REG_WR = 1'h0;
		REG_RD = 1'h0;
		PLL_REFERENCE = 1'h0;
	end
	// A disabled source stands still instead of running free
	initial forever #62.5 if (ref_run) PLL_REFERENCE = !PLL_REFERENCE;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WR <= 1'h0;
		REG_ADDR <= ~a;
		REG_WDATA <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'h0;
		REG_ADDR <= ~a;
		@(posedge CLK);
		d = REG_RDATA;
	endtask : rd
endmodule : host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the main clock and reset control block.
// Assumes host_model drives the register port; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import clkrst_pkg::*;
	localparam int STOP_N = 3;
	localparam int START_N = 4;
	logic clk, sys_rst, supply_rst, ext_rst_low, slave, wr, rd, pll_ref;
	logic en, rdy, aud_rst, fr_ref, irq_o, irq_oe;
	logic [7:0] addr, wdata, rdata, mic, cfg;
	logic [3:0] filt;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	host_model host (.CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .PLL_REFERENCE(pll_ref));
	main_clock_reset_control #(.STOP_CYCLES(STOP_N), .START_CYCLES(START_N)) dut (
		.CLK(clk), .SYS_RST(sys_rst), .SUPPLY_MONITOR_RESET(supply_rst),
		.EXTERNAL_RESET_LOW(ext_rst_low), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .PLL_REFERENCE(pll_ref),
		.AUDIO_FRAME_CLOCK(pll_ref),
		.AUDIO_PORT_SLAVE(slave), .MIC_LEVEL(mic), .MAIN_CLOCK_ENABLE(en),
		.MAIN_CLOCK_READY(rdy), .AUDIO_FUNCTIONS_RESET(aud_rst), .CLOCK_CONFIG(cfg),
		.REF_DIVIDER(), .FEEDBACK_DIVIDER(), .PLL_FILTER_RES(filt), .SYSTEM_ENABLE(),
		.PLL_REF_FROM_FRAME(fr_ref), .INTERRUPT_OUT_LOW_O(irq_o),
		.INTERRUPT_OUT_LOW_OE(irq_oe));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		check(d, e);
	endtask : rdc
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	task automatic t_idle();
		rdc(OFS_CLOCK_STATE, 8'h04);
		host.wr(OFS_INT_MASK, 8'h01);
		rdc(OFS_INT_MASK, 8'h01);
		rdc(8'hff, 8'h00);
	endtask : t_idle
	task automatic t_start();
		mic <= 8'h20;
		host.wr(OFS_SYSTEM_ENABLE, 8'h00);
		host.wr(OFS_CLOCK_CONFIG, 8'h04);
		host.wr(OFS_COMMAND, CMD_CLOCK_START);
		for (n = 0; n < 50 && rdy !== 1'h1; n++) @(posedge clk);
		check(n inside {[START_N:START_N + 4]}, 8'h01);
		host.wr(OFS_MIC_THRESHOLD, 8'h10);
		repeat (2) @(posedge clk);
		check(aud_rst, 8'h00);
		check(irq_oe, 8'h01);
		rdc(OFS_INT_STATUS, 8'h03);
		rdc(OFS_INT_STATUS, 8'h02);
		repeat (3) @(posedge clk);
		check(irq_oe, 8'h00);
		mic <= 8'h00;
	endtask : t_start
	task automatic t_lock_stop();
		host.wr(OFS_CLOCK_CONFIG, 8'h55);
		rdc(OFS_CLOCK_CONFIG, 8'h04);
		host.wr(OFS_SYSTEM_ENABLE, 8'h00);
		host.wr(OFS_COMMAND, CMD_CLOCK_STOP);
		for (n = 0; n < 50 && en !== 1'h0; n++) @(posedge clk);
		check(n <= STOP_N + 2, 8'h01);
		check(aud_rst, 8'h01);
		slave <= 1'h1;
		host.wr(OFS_CLOCK_CONFIG, 8'h1c);
		host.wr(OFS_PLL_CONFIG, 8'ha3);
		repeat (4) @(posedge clk);
		check(cfg, 8'h1c);
		check(fr_ref, 8'h01);
		check(filt, 8'h0a);
		slave <= 1'h0;
		repeat (4) @(posedge clk);
		check(fr_ref, 8'h00);
	endtask : t_lock_stop
	task automatic t_resets();
		host.wr(OFS_COMMAND, CMD_CLOCK_START);
		repeat (12) @(posedge clk);
		host.wr(OFS_COMMAND, CMD_CLOCK_STOP);
		// Reference keeps running past the stop before it is parked
		repeat (4) @(posedge pll_ref);
		host.ref_run = 1'h0;
		@(posedge clk);
		ext_rst_low <= 1'h0;
		repeat (130) @(posedge clk);
		check(en, 8'h00);
		check(cfg, 8'h00);
		ext_rst_low <= 1'h1;
		repeat (3) @(posedge clk);
		host.wr(OFS_PLL_CONFIG, 8'h70);
		supply_rst <= 1'h1;
		repeat (8) @(posedge clk);
		supply_rst <= 1'h0;
		repeat (3) @(posedge clk);
		check(filt, 8'h00);
		rdc(OFS_CLOCK_STATE, 8'h04);
	endtask : t_resets
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		sys_rst = 1'h1;
		supply_rst = 1'h0;
		ext_rst_low = 1'h1;
		slave = 1'h0;
		mic = 8'h00;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (3) @(posedge clk);
		t_idle();
		t_start();
		t_lock_stop();
		t_resets();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
